/* File: hdl/dcas_pkg.sv */
// shared constants and carrier types for the discrete command and analog source block
package dcas_pkg;

  localparam int unsigned DCAS_CLK_MHZ = 100;
  // contact debounce time in microseconds
  localparam int unsigned DCAS_DEBOUNCE_US = 10;
  localparam int unsigned DCAS_DEBOUNCE_CYC = DCAS_DEBOUNCE_US * DCAS_CLK_MHZ;
  localparam int unsigned DCAS_DB_W = 10;
  // length of the internal alarm reset pulse
  localparam int unsigned DCAS_RESET_CYC = 1;

  localparam int unsigned DCAS_NUM_DI = 8;
  localparam int unsigned DCAS_NUM_AO = 3;
  localparam int unsigned DCAS_VAL_W = 16;

  // discrete input positions
  localparam int unsigned DCAS_DI_PROC_EN = 0;
  localparam int unsigned DCAS_DI_ALM_RST = 1;
  localparam int unsigned DCAS_DI_SPD_OVR = 2;
  localparam int unsigned DCAS_DI_DYN2 = 3;
  localparam int unsigned DCAS_DI_RAISE = 4;
  localparam int unsigned DCAS_DI_LOWER = 5;

  // holding register addresses of the modbus written analog outputs
  localparam logic [15:0] DCAS_HR_AO1 = 16'h0002;
  localparam logic [15:0] DCAS_HR_AO2 = 16'h0003;
  localparam logic [15:0] DCAS_HR_AO4 = 16'h0004;

  typedef enum logic [3:0] {
    DCAS_SRC_SPEED = 4'h1,
    DCAS_SRC_SPEED_REF = 4'h2,
    DCAS_SRC_FUEL = 4'h3,
    DCAS_SRC_REV_FUEL = 4'h4,
    DCAS_SRC_TORSION = 4'h5,
    DCAS_SRC_REMOTE_SP = 4'h6,
    DCAS_SRC_MODBUS = 4'h7,
    DCAS_SRC_PROC1 = 4'h8,
    DCAS_SRC_PROC2 = 4'h9,
    DCAS_SRC_PROC_DIFF = 4'ha
  } dcas_src_t;

  // reset sources and defaults
  localparam dcas_src_t DCAS_AO1_SRC_RST = DCAS_SRC_SPEED;
  localparam dcas_src_t DCAS_AO2_SRC_RST = DCAS_SRC_SPEED_REF;
  localparam dcas_src_t DCAS_AO4_SRC_RST = DCAS_SRC_FUEL;
  localparam logic [15:0] DCAS_RPM_FULL_RST = 16'h0514;
  localparam logic [15:0] DCAS_PCT_FULL_RST = 16'h0064;
  localparam logic [15:0] DCAS_FULL_CODE = 16'hffff;

  typedef struct packed {
    logic [15:0] speed;
    logic [15:0] speed_ref;
    logic [15:0] fuel;
    logic [15:0] torsion;
    logic [15:0] remote_sp;
    logic [15:0] proc1;
    logic [15:0] proc2;
  } dcas_meas_t;

  typedef struct packed {
    logic [15:0] hr_ao1;
    logic [15:0] hr_ao2;
    logic [15:0] hr_ao4;
  } dcas_mb_t;

  typedef enum logic [1:0] {
    DCAS_RST_IDLE = 2'b00,
    DCAS_RST_PULSE = 2'b01,
    DCAS_RST_WAIT_OPEN = 2'b11
  } dcas_rst_state_t;

endpackage

/* File: hdl/dcas_debounce.sv */
// two-flop synchroniser and debounce filter for one contact input
`timescale 1ns/1ps
module dcas_debounce (
  input wire logic clock,
  input wire logic reset,
  input wire logic raw,
  output logic level
);

  logic sync1_q;
  logic sync2_q;
  logic [dcas_pkg::DCAS_DB_W-1:0] cnt_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  // level only follows after the sync output is steady for the whole window
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_q <= '0;
      level <= 1'b0;
    end else if (sync2_q == level) begin
      cnt_q <= '0;
    end else if (cnt_q == dcas_pkg::DCAS_DB_W'(dcas_pkg::DCAS_DEBOUNCE_CYC - 1)) begin
      cnt_q <= '0;
      level <= sync2_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule // dcas_debounce

/* File: hdl/dcas_scale.sv */
// scales one engineering value to a full-range output code
`timescale 1ns/1ps
module dcas_scale (
  input wire logic clock,
  input wire logic reset,
  input wire logic [15:0] value,
  input wire logic [15:0] full,
  input wire logic bypass,
  output logic [15:0] code
);

  logic [31:0] prod;
  logic [31:0] quot;

  always_comb begin
    prod = 32'(value) * 32'(dcas_pkg::DCAS_FULL_CODE);
    quot = (full == 16'h0000) ? 32'h0000_0000 : prod / 32'(full);
  end

  // clamp keeps an over-range value at full scale instead of wrapping
  always_ff @(posedge clock) begin
    if (reset) begin
      code <= '0;
    end else if (bypass) begin
      code <= value;
    end else if (quot > 32'(dcas_pkg::DCAS_FULL_CODE)) begin
      code <= dcas_pkg::DCAS_FULL_CODE;
    end else begin
      code <= quot[15:0];
    end
  end

endmodule // dcas_scale

/* File: hdl/dcas_top.sv */
// discrete command inputs and analog output source selection
//
// How it works
// RQ1: each analog output picks one of ten sources by software code.
// RQ2: modbus source uses holding registers 2, 3, 4 for the three outputs.
// RQ3: defaults: out1 speed, out2 reference over 1300 rpm; out4 fuel over 100 %.
// RQ4: software must rescale outputs when the current range is changed.
// RQ5: contact closed means TRUE, open terminal means FALSE.
// RQ6: each input lights its indicator while validly TRUE.
// RQ7: process disabled: speed follows raise, lower and remote reference.
// RQ8: process enabled: only process control moves speed.
// RQ9: process control drives speed toward restoring the process set point.
// RQ10: alarm reset clears only latched alarms whose condition is normal.
// RQ11: internal reset lasts a short fixed time even if held closed.
// RQ12: new reset only after the input returns to FALSE.
// RQ13: input, two serial ports and software switch all trigger reset.
// RQ14: override TRUE suppresses sensor-loss shutdown, lets fuel rise.
// RQ15: override FALSE: shut down when both speed sensors are lost.
// RQ16: reverse acting with override held TRUE forces fuel up on loss.
// RQ17: direct acting installations keep the override open in normal running.
// RQ18: expansion module values go to both ports; outputs driven from port three.
// RQ19: process enable removes raise authority over the speed reference.
// RQ20: inputs are synchronised, debounced, and reset edge makes a pulse.
`timescale 1ns/1ps
module dcas_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] contact_in,
  input wire dcas_pkg::dcas_meas_t meas,
  input wire dcas_pkg::dcas_mb_t mb_hr,
  input wire logic [47:0] ao_src_sel,
  input wire logic [47:0] ao_full_scale,
  input wire logic [2:0] ao_sel_valid,
  input wire logic reset_cmd_serial_port_two,
  input wire logic reset_cmd_serial_port_three,
  input wire logic reset_cmd_soft_switch,
  input wire logic [7:0] alarm_cond,
  input wire logic sensor1_lost,
  input wire logic sensor2_lost,
  input wire logic reverse_acting,
  input wire logic [15:0] proc_setpoint,
  input wire logic proc_diff_mode,
  input wire logic [15:0] exp_in_value,
  input wire logic [15:0] exp_out_port_three,
  output logic [7:0] di_led,
  output logic [7:0] di_state,
  output logic [47:0] ao_code,
  output logic [7:0] alarm_latched,
  output logic alarm_reset_pulse,
  output logic process_active,
  output logic speed_raise_cmd,
  output logic speed_lower_cmd,
  output logic remote_ref_en,
  output logic proc_raise_cmd,
  output logic proc_lower_cmd,
  output logic sensor_loss_shutdown,
  output logic fuel_force_up,
  output logic fuel_rise_allowed,
  output logic [15:0] exp_to_serial_port_two,
  output logic [15:0] exp_to_serial_port_three,
  output logic [15:0] exp_out_drive
);

  logic [7:0] di_level;
  dcas_pkg::dcas_src_t src_q [dcas_pkg::DCAS_NUM_AO];
  logic [15:0] full_q [dcas_pkg::DCAS_NUM_AO];
  logic [15:0] sel_val [dcas_pkg::DCAS_NUM_AO];
  logic [15:0] hr_val [dcas_pkg::DCAS_NUM_AO];
  logic [15:0] mb_code [dcas_pkg::DCAS_NUM_AO];
  logic [dcas_pkg::DCAS_NUM_AO-1:0] is_mb;
  dcas_pkg::dcas_rst_state_t rst_state_q;
  dcas_pkg::dcas_rst_state_t rst_state_d;
  logic [1:0] pulse_cnt_q;
  logic rst_any;
  logic [15:0] proc_meas;
  logic both_lost;
  logic any_lost;
  logic [7:0] alarm_clear;
  logic proc_below;
  logic proc_above;

  // per-input conditioning; a closed contact gives a TRUE level
  genvar gi;
  generate
    for (gi = 0; gi < dcas_pkg::DCAS_NUM_DI; gi++) begin : g_di
      dcas_debounce u_db ( // RQ20
        .clock(clock),
        .reset(reset),
        .raw(contact_in[gi]), // RQ5
        .level(di_level[gi])
      );
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (reset) begin
      di_state <= '0;
    end else begin
      di_state <= di_level; // RQ5
    end
  end

  // indicator has its own flop so it can be routed to the cover lamps
  always_ff @(posedge clock) begin
    if (reset) begin
      di_led <= '0;
    end else begin
      di_led <= di_level; // RQ6
    end
  end

  // source selection and default scaling per analog output
  always_comb begin
    hr_val[0] = mb_hr.hr_ao1;
    hr_val[1] = mb_hr.hr_ao2;
    hr_val[2] = mb_hr.hr_ao4;
  end

  generate
    for (gi = 0; gi < dcas_pkg::DCAS_NUM_AO; gi++) begin : g_ao
      always_ff @(posedge clock) begin
        if (reset) begin
          src_q[gi] <= (gi == 0) ? dcas_pkg::DCAS_AO1_SRC_RST :
                       (gi == 1) ? dcas_pkg::DCAS_AO2_SRC_RST :
                       dcas_pkg::DCAS_AO4_SRC_RST; // RQ3
        end else if (ao_sel_valid[gi]) begin
          src_q[gi] <= dcas_pkg::dcas_src_t'(ao_src_sel[gi*16 +: 4]); // RQ1
        end
      end

      // rescaling for a changed current range is left to software
      always_ff @(posedge clock) begin
        if (reset) begin
          full_q[gi] <= (gi == 2) ? dcas_pkg::DCAS_PCT_FULL_RST :
                        dcas_pkg::DCAS_RPM_FULL_RST; // RQ3
        end else if (ao_sel_valid[gi]) begin
          full_q[gi] <= ao_full_scale[gi*16 +: 16]; // RQ4
        end
      end

      always_comb begin
        is_mb[gi] = 1'b0;
        unique case (src_q[gi]) // RQ1
          dcas_pkg::DCAS_SRC_SPEED: sel_val[gi] = meas.speed;
          dcas_pkg::DCAS_SRC_SPEED_REF: sel_val[gi] = meas.speed_ref;
          dcas_pkg::DCAS_SRC_FUEL: sel_val[gi] = meas.fuel;
          dcas_pkg::DCAS_SRC_REV_FUEL: sel_val[gi] = 16'(16'h0064 - meas.fuel);
          dcas_pkg::DCAS_SRC_TORSION: sel_val[gi] = meas.torsion;
          dcas_pkg::DCAS_SRC_REMOTE_SP: sel_val[gi] = meas.remote_sp;
          dcas_pkg::DCAS_SRC_MODBUS: begin
            sel_val[gi] = hr_val[gi]; // RQ2
            is_mb[gi] = 1'b1;
          end
          dcas_pkg::DCAS_SRC_PROC1: sel_val[gi] = meas.proc1;
          dcas_pkg::DCAS_SRC_PROC2: sel_val[gi] = meas.proc2;
          dcas_pkg::DCAS_SRC_PROC_DIFF: sel_val[gi] = 16'(meas.proc1 - meas.proc2);
          default: sel_val[gi] = 16'h0000;
        endcase
      end

      // modbus value is already an output code, so it skips scaling
      dcas_scale u_scale (
        .clock(clock),
        .reset(reset),
        .value(sel_val[gi]),
        .full(full_q[gi]),
        .bypass(is_mb[gi]), // RQ2
        .code(mb_code[gi])
      );

      always_ff @(posedge clock) begin
        if (reset) begin
          ao_code[gi*16 +: 16] <= '0;
        end else begin
          ao_code[gi*16 +: 16] <= mb_code[gi];
        end
      end
    end
  endgenerate

  // alarm reset: one pulse per closure, rearmed only by reopening
  assign rst_any = reset_cmd_serial_port_two | reset_cmd_serial_port_three |
                   reset_cmd_soft_switch; // RQ13

  always_comb begin
    rst_state_d = rst_state_q;
    unique case (rst_state_q)
      dcas_pkg::DCAS_RST_IDLE: begin
        if (di_level[dcas_pkg::DCAS_DI_ALM_RST] || rst_any) begin
          rst_state_d = dcas_pkg::DCAS_RST_PULSE; // RQ20
        end
      end
      dcas_pkg::DCAS_RST_PULSE: begin
        if (pulse_cnt_q == 2'(dcas_pkg::DCAS_RESET_CYC - 1)) begin
          rst_state_d = dcas_pkg::DCAS_RST_WAIT_OPEN; // RQ11
        end
      end
      dcas_pkg::DCAS_RST_WAIT_OPEN: begin
        if (!di_level[dcas_pkg::DCAS_DI_ALM_RST] && !rst_any) begin
          rst_state_d = dcas_pkg::DCAS_RST_IDLE; // RQ12
        end
      end
      default: rst_state_d = dcas_pkg::DCAS_RST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rst_state_q <= dcas_pkg::DCAS_RST_IDLE;
    end else begin
      rst_state_q <= rst_state_d;
    end
  end

  // counts cycles spent in the pulse state, zero elsewhere
  always_ff @(posedge clock) begin
    if (reset) begin
      pulse_cnt_q <= '0;
    end else if (rst_state_q == dcas_pkg::DCAS_RST_PULSE) begin
      pulse_cnt_q <= 2'(pulse_cnt_q + 1'b1);
    end else begin
      pulse_cnt_q <= 2'b00;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      alarm_reset_pulse <= 1'b0;
    end else begin
      alarm_reset_pulse <= (rst_state_d == dcas_pkg::DCAS_RST_PULSE); // RQ11
    end
  end

  // only bits whose condition is normal during the pulse may clear
  assign alarm_clear = (rst_state_q == dcas_pkg::DCAS_RST_PULSE) ?
                       ~alarm_cond : 8'h00; // RQ10

  // a fault in the same cycle as the reset keeps its latch (set wins)
  always_ff @(posedge clock) begin
    if (reset) begin
      alarm_latched <= '0;
    end else begin
      alarm_latched <= (alarm_latched & ~alarm_clear) | alarm_cond; // RQ10
    end
  end

  // speed command authority
  assign proc_meas = proc_diff_mode ? 16'(meas.proc1 - meas.proc2) : meas.proc1;

  always_ff @(posedge clock) begin
    if (reset) begin
      process_active <= 1'b0;
    end else begin
      process_active <= di_level[dcas_pkg::DCAS_DI_PROC_EN]; // RQ8
    end
  end

  // manual commands lose authority as soon as process control is enabled
  always_ff @(posedge clock) begin
    if (reset) begin
      speed_raise_cmd <= 1'b0;
      speed_lower_cmd <= 1'b0;
      remote_ref_en <= 1'b0;
    end else begin
      speed_raise_cmd <= !di_level[dcas_pkg::DCAS_DI_PROC_EN] &&
                         di_level[dcas_pkg::DCAS_DI_RAISE]; // RQ19
      speed_lower_cmd <= !di_level[dcas_pkg::DCAS_DI_PROC_EN] &&
                         di_level[dcas_pkg::DCAS_DI_LOWER]; // RQ7
      remote_ref_en <= !di_level[dcas_pkg::DCAS_DI_PROC_EN] &&
                       di_level[dcas_pkg::DCAS_DI_RAISE] &&
                       di_level[dcas_pkg::DCAS_DI_LOWER]; // RQ7
    end
  end

  // process below set point needs more speed
  assign proc_below = proc_meas < proc_setpoint;
  assign proc_above = proc_meas > proc_setpoint;

  always_ff @(posedge clock) begin
    if (reset) begin
      proc_raise_cmd <= 1'b0;
      proc_lower_cmd <= 1'b0;
    end else begin
      proc_raise_cmd <= di_level[dcas_pkg::DCAS_DI_PROC_EN] && proc_below; // RQ9
      proc_lower_cmd <= di_level[dcas_pkg::DCAS_DI_PROC_EN] && proc_above; // RQ9
    end
  end

  // speed sensor loss handling
  assign both_lost = sensor1_lost & sensor2_lost;
  assign any_lost = sensor1_lost | sensor2_lost;

  always_ff @(posedge clock) begin
    if (reset) begin
      sensor_loss_shutdown <= 1'b0;
    end else begin
      sensor_loss_shutdown <= both_lost && !di_level[dcas_pkg::DCAS_DI_SPD_OVR]; // RQ15
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      fuel_rise_allowed <= 1'b0;
    end else begin
      fuel_rise_allowed <= di_level[dcas_pkg::DCAS_DI_SPD_OVR] || !both_lost; // RQ14
    end
  end

  // the override is expected held TRUE by wiring on reverse acting engines
  always_ff @(posedge clock) begin
    if (reset) begin
      fuel_force_up <= 1'b0;
    end else begin
      fuel_force_up <= reverse_acting && di_level[dcas_pkg::DCAS_DI_SPD_OVR] &&
                       any_lost; // RQ16
    end
  end

  // expansion module routing
  always_ff @(posedge clock) begin
    if (reset) begin
      exp_to_serial_port_two <= '0;
    end else begin
      exp_to_serial_port_two <= exp_in_value; // RQ18
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      exp_to_serial_port_three <= '0;
    end else begin
      exp_to_serial_port_three <= exp_in_value; // RQ18
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      exp_out_drive <= '0;
    end else begin
      exp_out_drive <= exp_out_port_three; // RQ18
    end
  end

endmodule // dcas_top

/* File: sim/dcas_assertions.sv */
// concurrent checks on the discrete command block ports
`timescale 1ns/1ps
module dcas_assertions (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] di_state,
  input wire logic [7:0] di_led,
  input wire logic [7:0] alarm_cond,
  input wire logic [7:0] alarm_latched,
  input wire logic alarm_reset_pulse,
  input wire logic process_active,
  input wire logic speed_raise_cmd,
  input wire logic speed_lower_cmd,
  input wire logic remote_ref_en,
  input wire logic sensor1_lost,
  input wire logic sensor2_lost,
  input wire logic reverse_acting,
  input wire logic sensor_loss_shutdown,
  input wire logic fuel_force_up
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_reset_taken;
    alarm_reset_pulse ##1 $stable(alarm_cond) [*2];
  endsequence
  sequence s_both_lost;
    (!di_state[2] && sensor1_lost && sensor2_lost) [*3];
  endsequence
  a_led_tracks_state: assert property (di_led == di_state)
    else $error("indicator differs from input state");
  a_pulse_one_cycle: assert property (alarm_reset_pulse |=> !alarm_reset_pulse)
    else $error("reset pulse longer than one cycle");
  a_clear_only_normal: assert property (s_reset_taken |-> (alarm_latched & ~alarm_cond) == 8'h00)
    else $error("normal alarm not cleared");
  a_fault_stays_latched: assert property (alarm_reset_pulse |-> ##2 ((alarm_latched & $past(alarm_cond, 2)) == $past(alarm_cond, 2)))
    else $error("faulted alarm cleared");
  a_proc_follows_input: assert property ($stable(di_state[0]) [*2] |-> process_active == di_state[0])
    else $error("process mode not following input");
  a_proc_blocks_manual: assert property (process_active |-> !speed_raise_cmd && !speed_lower_cmd && !remote_ref_en)
    else $error("manual command active in process mode");
  a_loss_shuts_down: assert property (s_both_lost |-> sensor_loss_shutdown)
    else $error("no shutdown on loss of both sensors");
  a_override_holds_off: assert property (di_state[2] [*2] |-> !sensor_loss_shutdown)
    else $error("shutdown while override true");
  a_reverse_forces_fuel: assert property ((reverse_acting && di_state[2] && sensor1_lost) [*3] |-> fuel_force_up)
    else $error("fuel not forced up on reverse acting loss");
endmodule // dcas_assertions
bind dcas_top dcas_assertions dcas_assertions_i (.*);

/* File: sim/dcas_contacts.sv */
// contact bank model: closed contact drives its terminal high, with bounce
`timescale 1ns/1ps
module dcas_contacts (
  input wire logic clock,
  input wire logic [7:0] want,
  output logic [7:0] contact_in
);
  logic [7:0] tgt = 8'h00;
  logic [7:0] old = 8'h00;
  logic [3:0] bnc = 4'h0;
  // open terminal reads low, closed reads high; chatter before settling
  always @(posedge clock) begin
    if (want !== tgt) begin
      old <= tgt;
      tgt <= want;
      bnc <= 4'h7;
    end else if (bnc != 4'h0) begin
      bnc <= bnc - 4'h1;
    end
    contact_in <= (bnc != 4'h0 && bnc[0]) ? old : tgt;
  end
endmodule // dcas_contacts

/* File: sim/tb_top.sv */
// self-checking bench for the discrete command block
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic [7:0] want = 8'h00;
  logic [7:0] contact_in;
  dcas_pkg::dcas_meas_t meas = '0;
  dcas_pkg::dcas_mb_t mb_hr = '0;
  logic [47:0] sel = '0;
  logic [47:0] full = '0;
  logic [47:0] ao_code;
  logic [2:0] ld = 3'h0;
  logic rs2 = 1'h0, rs3 = 1'h0, rsw = 1'h0, s1 = 1'h0, s2 = 1'h0, rev = 1'h0;
  logic pdm = 1'h0;
  logic [7:0] cond = 8'h00;
  logic [7:0] di_led, di_state, latched;
  logic [15:0] sp = 16'h0000, exi = 16'h0000, exo = 16'h0000, ep2, ep3, epd;
  logic pulse, pact, rcmd, lcmd, rref, praise, plower, shut, fup, frise;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  dcas_contacts dcas_contacts_i (.clock(clock), .want(want), .contact_in(contact_in));
  dcas_top dcas_top_i (.clock(clock), .reset(reset), .contact_in(contact_in),
    .meas(meas), .mb_hr(mb_hr), .ao_src_sel(sel), .ao_full_scale(full),
    .ao_sel_valid(ld), .reset_cmd_serial_port_two(rs2),
    .reset_cmd_serial_port_three(rs3), .reset_cmd_soft_switch(rsw),
    .alarm_cond(cond), .sensor1_lost(s1), .sensor2_lost(s2), .reverse_acting(rev),
    .proc_setpoint(sp), .proc_diff_mode(pdm), .exp_in_value(exi),
    .exp_out_port_three(exo), .di_led(di_led), .di_state(di_state), .ao_code(ao_code),
    .alarm_latched(latched), .alarm_reset_pulse(pulse), .process_active(pact),
    .speed_raise_cmd(rcmd), .speed_lower_cmd(lcmd), .remote_ref_en(rref),
    .proc_raise_cmd(praise), .proc_lower_cmd(plower), .sensor_loss_shutdown(shut),
    .fuel_force_up(fup), .fuel_rise_allowed(frise), .exp_to_serial_port_two(ep2),
    .exp_to_serial_port_three(ep3), .exp_out_drive(epd));
  always #5 clock = ~clock;
  task conclude;
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // generous ceiling, the run needs under ten thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude;
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task cy(input int n);
    repeat (n) @(posedge clock);
  endtask
  task t_defaults;
    meas <= {16'h028a, 16'h0514, 16'h0032, 64'h0};
    cy(5);
    chk(ao_code[15:0], 16'h7fff);
    chk(ao_code[31:16], 16'hffff);
    chk(ao_code[47:32], 16'h7fff);
  endtask
  task t_sources;
    logic [15:0] e [1:10];
    e = '{16'h000b, 16'h0016, 16'h0021, 16'h0043, 16'h002c, 16'h0037, 16'h0a01,
      16'h0042, 16'h0006, 16'h003c};
    meas <= {16'h000b, 16'h0016, 16'h0021, 16'h002c, 16'h0037, 16'h0042, 16'h0006};
    mb_hr <= {16'h0a01, 16'h0a02, 16'h0a04};
    for (int k = 1; k <= 10; k++) begin
      sel <= {3{12'h000, 4'(k)}};
      full <= {3{16'hffff}};
      ld <= 3'h7;
      cy(1);
      ld <= 3'h0;
      cy(4);
      chk(ao_code[15:0], e[k]);
      chk(ao_code[31:16], k == 7 ? 16'h0a02 : e[k]);
      chk(ao_code[47:32], k == 7 ? 16'h0a04 : e[k]);
    end
  endtask
  task t_debounce;
    want <= 8'h30;
    cy(900);
    chk(di_state[4], 1'h0);
    cy(300);
    chk(di_state[4], 1'h1);
    chk(di_led[4], 1'h1);
    chk(rcmd, 1'h1);
    chk(lcmd, 1'h1);
    chk(rref, 1'h1);
  endtask
  task t_process;
    sp <= 16'h0064;
    meas.proc1 <= 16'h0032;
    want <= 8'h31;
    cy(1200);
    chk(pact, 1'h1);
    chk(rcmd, 1'h0);
    chk(lcmd, 1'h0);
    chk(rref, 1'h0);
    chk(praise, 1'h1);
    meas.proc1 <= 16'h0096;
    cy(4);
    chk(plower, 1'h1);
    chk(praise, 1'h0);
    meas.proc2 <= 16'h0050;
    pdm <= 1'h1;
    cy(4);
    chk(praise, 1'h1);
    chk(plower, 1'h0);
    pdm <= 1'h0;
    want <= 8'h00;
    cy(1200);
    chk(pact, 1'h0);
  endtask
  task t_alarm;
    int n;
    n = 0;
    cond <= 8'h03;
    cy(3);
    cond <= 8'h01;
    cy(3);
    chk(latched, 8'h03);
    want <= 8'h02;
    repeat (1300) begin
      @(posedge clock);
      n += pulse;
    end
    chk(n[15:0], 16'h0001);
    chk(latched, 8'h01);
    cond <= 8'h00;
    rs2 <= 1'h1;
    cy(20);
    chk(latched, 8'h01);
    rs2 <= 1'h0;
    want <= 8'h00;
    cy(1200);
    chk(latched, 8'h01);
    for (int k = 0; k < 3; k++) begin
      cond <= 8'h04;
      cy(3);
      cond <= 8'h00;
      {rs2, rs3, rsw} <= 3'h4 >> k;
      cy(2);
      {rs2, rs3, rsw} <= 3'h0;
      cy(4);
      chk(latched, 8'h00);
    end
  endtask
  task t_speed;
    s1 <= 1'h1;
    s2 <= 1'h1;
    cy(5);
    chk(shut, 1'h1);
    want <= 8'h04;
    cy(1200);
    chk(shut, 1'h0);
    chk(frise, 1'h1);
    chk(fup, 1'h0);
    rev <= 1'h1;
    cy(5);
    chk(fup, 1'h1);
    rev <= 1'h0;
    s1 <= 1'h0;
    s2 <= 1'h0;
    want <= 8'h00;
    cy(1200);
  endtask
  task t_exp;
    exi <= 16'h1234;
    exo <= 16'h5678;
    cy(4);
    chk(ep2, 16'h1234);
    chk(ep3, 16'h1234);
    chk(epd, 16'h5678);
  endtask
  initial begin
    cy(8);
    reset <= 1'h0;
    cy(2);
    t_defaults;
    t_sources;
    t_debounce;
    t_process;
    t_alarm;
    t_speed;
    t_exp;
    conclude;
  end
endmodule // tb_top
